// file: sprc_defines.vh
`ifndef SPRC_DEFINES_VH
`define SPRC_DEFINES_VH
// ===========================================================
// register offsets
`define SPRC_REG_LOG 16'h000A
`define SPRC_REG_PTR 16'h000B
`define SPRC_REG_ACTIVE 16'h000F
// ===========================================================
// command bytes
`define SPRC_OP_SEQ 8'h40
`define SPRC_OP_LOGRD 8'h58
`define SPRC_OP_POLL 8'h60
`define SPRC_OP_INC 8'hD0
`define SPRC_OP_SEL 8'hD8
`define SPRC_OP_LOAD 8'h8B
`define SPRC_OP_RD_LOG 8'h28
`define SPRC_OP_RD_PTR 8'h2C
`define SPRC_OP_RD_ACTIVE 8'h3C
// ===========================================================
// interrupt log, descriptor table, fields
`define SPRC_LOG_FIRST 9'h180
`define SPRC_LOG_LAST 9'h1BF
`define SPRC_LOG_PENULT 9'h1BE
`define SPRC_TABLE_BASE 16'h0400
`define SPRC_TABLE_SPAN 16'h01FF
`define SPRC_POLL_STEP 16'h0004
`define SPRC_FLAG_BIT 15
`define SPRC_CMD_BITS 4'h7
`define SPRC_WORD_BITS 4'hF
`define SPRC_PTR_RESET 16'h0000
`define SPRC_COUNT_MAX 7'h7F
`endif

// file: sprc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sprc_defines.vh"

// ===========================================================
// write buffer between interrupt logger and ram
module sprc_fifo #(
  parameter W = 29,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rstn,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam [AW:0] FULL = D;
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rp];

  always @(posedge clock) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // depth must be a power of two so the pointers wrap by themselves
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wp <= wp + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp <= rp + {{(AW-1){1'b0}}, 1'b1};
      end
      count <= next_count;
      in_ready <= (next_count < FULL);
    end
  end
endmodule // sprc_fifo

// ===========================================================
// spi pointer read engine with ram, interrupt log and flags
module sprc_top #(
  parameter AW = 13,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clock,
  input wire rstn,
  input wire sck,
  input wire cs_n,
  input wire mosi,
  output reg miso,
  output reg miso_oe,
  input wire [15:0] table_base,
  input wire flag_set,
  input wire [6:0] flag_index,
  input wire rt_wr,
  input wire [AW-1:0] rt_addr,
  input wire [15:0] rt_wdata,
  input wire irq_valid,
  output reg irq_ready,
  input wire [15:0] irq_info,
  input wire [15:0] irq_addr_word,
  output reg [15:0] active_pointer
);
  localparam [2:0] M_IDLE = 3'd0;
  localparam [2:0] M_UP = 3'd1;
  localparam [2:0] M_POLL = 3'd2;
  localparam [2:0] M_LOG = 3'd3;
  localparam [2:0] M_REG = 3'd4;
  localparam [2:0] M_LOAD = 3'd5;
  localparam [1:0] L_IDLE = 2'd0;
  localparam [1:0] L_INFO = 2'd1;
  localparam [1:0] L_ADDR = 2'd2;

  function is_ctl;
    input [15:0] a;
    input [15:0] b;
    reg [15:0] off;
    begin
      off = a - b;
      is_ctl = (a >= b) && (off <= `SPRC_TABLE_SPAN) && (off[1:0] == 2'b00);
    end
  endfunction

  // step down inside the log, wrapping to its last word
  function [15:0] log_dec;
    input [15:0] a;
    begin
      if (a[8:0] == `SPRC_LOG_FIRST) begin
        log_dec = {7'h00, `SPRC_LOG_LAST};
      end else begin
        log_dec = {7'h00, a[8:0] - 9'h001};
      end
    end
  endfunction

  // ===========================================================
  // pin synchronisers
  reg sck_s1, sck_s2, sck_s3;
  reg cs_s1, cs_s2;
  reg mosi_s1, mosi_s2;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      mosi_s1 <= mosi;
      mosi_s2 <= mosi_s1;
    end
  end
  wire rise = sck_s2 & ~sck_s3;
  wire fall = ~sck_s2 & sck_s3;
  wire selected = ~cs_s2;

  // ===========================================================
  // state
  reg [2:0] mode;
  reg in_cmd;
  reg [3:0] bitc;
  reg [6:0] cmd_sh;
  reg [15:0] rx;
  reg [15:0] tx;
  reg [15:0] next_word;
  reg rd_go;
  reg [15:0] rd_addr;
  reg rd_done;
  reg [15:0] rd_word;
  reg rd_ctl;
  reg rd_flag;
  reg log_clr;
  reg [8:0] log_next;
  reg [6:0] log_count;
  reg [1:0] lg_state;
  reg [15:0] lg_info;
  reg [15:0] lg_addr;
  reg [127:0] acc_flag;
  reg [15:0] mem [0:(1<<AW)-1];

  wire [7:0] cmd_byte = {cmd_sh, mosi_s2};
  wire [15:0] rx_word = {rx[14:0], mosi_s2};
  wire [15:0] log_reg = {log_count, log_next};
  wire [15:0] rd_off = rd_addr - table_base;
  wire [15:0] flag_mask = 16'h0001 << `SPRC_FLAG_BIT;
  wire [15:0] merged = rd_ctl ?
    ((rd_word & ~flag_mask) | (rd_flag ? flag_mask : 16'h0000)) : rd_word;
  wire reading = (mode == M_UP) || (mode == M_POLL) || (mode == M_LOG) ||
    (mode == M_REG);

  // pointer step taken when a word leaves for the host
  reg [15:0] next_ptr;
  reg blocked;
  always @* begin
    next_ptr = active_pointer;
    blocked = 1'b0;
    case (mode)
      // upward step; halt before a control word
      M_UP: begin
        next_ptr = active_pointer + 16'h0001;
        blocked = is_ctl(next_ptr, table_base);
      end
      M_POLL: begin
        next_ptr = active_pointer + `SPRC_POLL_STEP;
      end
      M_LOG: begin
        next_ptr = log_dec(active_pointer);
      end
      default: begin
        blocked = 1'b1;
      end
    endcase
  end

  // ===========================================================
  // serial engine
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode <= M_IDLE;
      in_cmd <= 1'b1;
      bitc <= 4'h0;
      cmd_sh <= 7'h00;
      rx <= 16'h0000;
      tx <= 16'h0000;
      next_word <= 16'h0000;
      rd_go <= 1'b0;
      rd_addr <= 16'h0000;
      log_clr <= 1'b0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      active_pointer <= `SPRC_PTR_RESET;
    end else begin
      rd_go <= 1'b0;
      log_clr <= 1'b0;
      if (rd_done) begin
        next_word <= merged;
      end
      if (!selected) begin
        mode <= M_IDLE;
        in_cmd <= 1'b1;
        bitc <= 4'h0;
        miso <= 1'b0;
        miso_oe <= 1'b0;
      end else if (rise && in_cmd) begin
        cmd_sh <= cmd_byte[6:0];
        bitc <= bitc + 4'h1;
        // command byte ends on the eighth clock
        if (bitc == `SPRC_CMD_BITS) begin
          in_cmd <= 1'b0;
          bitc <= 4'h0;
          mode <= M_IDLE;
          case (cmd_byte)
            `SPRC_OP_SEQ: begin
              mode <= M_UP;
              rd_go <= 1'b1;
              rd_addr <= active_pointer;
            end
            `SPRC_OP_POLL: begin
              mode <= M_POLL;
              rd_go <= 1'b1;
              rd_addr <= active_pointer;
            end
            // load the word below log bits 8:0 only, wrapping to the last log word, then read
            `SPRC_OP_LOGRD: begin
              mode <= M_LOG;
              active_pointer <= log_dec({7'h00, log_next});
              rd_go <= 1'b1;
              rd_addr <= log_dec({7'h00, log_next});
            end
            `SPRC_OP_INC: begin
              active_pointer <= active_pointer + 16'h0001;
            end
            // load pointer from the following word
            `SPRC_OP_LOAD: begin
              mode <= M_LOAD;
            end
            `SPRC_OP_RD_LOG: begin
              mode <= M_REG;
              next_word <= log_reg;
              log_clr <= 1'b1;
            end
            `SPRC_OP_RD_PTR, `SPRC_OP_RD_ACTIVE: begin
              mode <= M_REG;
              next_word <= active_pointer;
            end
            // the only pointer is always the enabled one
            default: begin
              mode <= M_IDLE;
            end
          endcase
        end
      end else if (rise) begin
        rx <= rx_word;
        bitc <= bitc + 4'h1;
        // sixteenth data bit completes the load
        if (bitc == `SPRC_WORD_BITS && mode == M_LOAD) begin
          active_pointer <= rx_word;
          mode <= M_IDLE;
        end
        // step and prefetch on the first clock of each word
        // stepping on the trailing fall would run one word ahead
        if (bitc == 4'h0 && reading && !blocked) begin
          active_pointer <= next_ptr;
          rd_go <= 1'b1;
          rd_addr <= next_ptr;
        end
      end else if (fall && !in_cmd && reading) begin
        miso_oe <= 1'b1;
        // word boundary every 16 clocks, msb first
        if (bitc == 4'h0) begin
          miso <= next_word[15];
          tx <= {next_word[14:0], 1'b0};
        end else begin
          miso <= tx[15];
          tx <= {tx[14:0], 1'b0};
        end
      end
    end
  end

  // ===========================================================
  // ram read and block accessed flags
  always @(posedge clock) begin
    if (rd_go) begin
      rd_word <= mem[rd_addr[AW-1:0]];
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_done <= 1'b0;
      rd_ctl <= 1'b0;
      rd_flag <= 1'b0;
      acc_flag <= 128'h0;
    end else begin
      rd_done <= rd_go;
      if (rd_go) begin
        rd_ctl <= is_ctl(rd_addr, table_base);
        rd_flag <= acc_flag[rd_off[8:2]];
      end
      // any control word read, prefetch included, clears; a set wins
      if (rd_go && is_ctl(rd_addr, table_base)) begin
        acc_flag[rd_off[8:2]] <= 1'b0;
      end
      if (flag_set) begin
        acc_flag[flag_index] <= 1'b1;
      end
    end
  end

  // ===========================================================
  // interrupt logger and write buffer
  wire [AW+15:0] f_out;
  wire f_valid;
  wire f_in_ready;
  wire lg_push = (lg_state != L_IDLE);
  wire [AW-1:0] lg_base = {{(AW-9){1'b0}}, log_next};
  wire [AW+15:0] f_in = (lg_state == L_INFO) ? {lg_base, lg_info} :
    {lg_base + {{(AW-1){1'b0}}, 1'b1}, lg_addr};

  sprc_fifo #(
    .W(AW+16),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(lg_push),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_valid),
    .out_ready(~rt_wr),
    .out_data(f_out)
  );

  // terminal writes take the port first and stall the drain
  always @(posedge clock) begin
    if (rt_wr) begin
      mem[rt_addr] <= rt_wdata;
    end else if (f_valid) begin
      mem[f_out[AW+15:16]] <= f_out[15:0];
    end
  end

  wire lg_finish = (lg_state == L_ADDR) && f_in_ready;
  wire [6:0] cnt_base = log_clr ? 7'h00 : log_count;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lg_state <= L_IDLE;
      lg_info <= 16'h0000;
      lg_addr <= 16'h0000;
      irq_ready <= 1'b1;
      log_next <= `SPRC_LOG_FIRST;
      log_count <= 7'h00;
    end else begin
      log_count <= cnt_base;
      case (lg_state)
        L_IDLE: begin
          if (irq_valid) begin
            lg_info <= irq_info;
            lg_addr <= irq_addr_word;
            lg_state <= L_INFO;
            irq_ready <= 1'b0;
          end
        end
        // info word at the even address, then address word
        L_INFO: begin
          if (f_in_ready) begin
            lg_state <= L_ADDR;
          end
        end
        L_ADDR: begin
          if (f_in_ready) begin
            lg_state <= L_IDLE;
            irq_ready <= 1'b1;
          end
        end
        default: begin
          lg_state <= L_IDLE;
          irq_ready <= 1'b1;
        end
      endcase
      // advance by two inside the log; count saturates
      if (lg_finish) begin
        if (log_next == `SPRC_LOG_PENULT) begin
          log_next <= `SPRC_LOG_FIRST;
        end else begin
          log_next <= log_next + 9'h002;
        end
        if (cnt_base != `SPRC_COUNT_MAX) begin
          log_count <= cnt_base + 7'h01;
        end
      end
    end
  end
endmodule // sprc_top
`default_nettype wire

// file: sprc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// port checker for the pointer read engine
module sprc_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic irq_valid,
  input wire logic irq_ready,
  input wire logic [15:0] active_pointer
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_oe_idle_off: assert property (cs_n [*6] |-> !miso_oe)
    else $error("miso driven while deselected");
  chk_oe_word_start: assert property ($rose(miso_oe) |-> !cs_n && !sck)
    else $error("miso enable rose outside a word start");
  chk_oe_word_hold: assert property (miso_oe && !cs_n |=> miso_oe)
    else $error("miso released while still selected");
  // shifting on the low phase keeps the host sample point clean
  chk_miso_low_shift: assert property ($changed(miso) |-> !sck && !$past(sck, 2))
    else $error("miso changed near a clock rise");
  chk_ptr_idle_hold: assert property (cs_n [*8] |=> $stable(active_pointer))
    else $error("pointer moved without a frame");
  chk_irq_take_busy: assert property (irq_valid && irq_ready |=> !irq_ready)
    else $error("logger ready right after a take");
  chk_irq_busy_ends: assert property ($fell(irq_ready) |-> ##[1:200] irq_ready)
    else $error("logger stuck busy");
  chk_irq_idle_keeps: assert property (irq_ready && !irq_valid |=> irq_ready)
    else $error("idle logger dropped ready");
endmodule // sprc_checker

bind sprc_top sprc_checker i_sprc_checker (
  .clock(clock),
  .rstn(rstn),
  .sck(sck),
  .cs_n(cs_n),
  .miso(miso),
  .miso_oe(miso_oe),
  .irq_valid(irq_valid),
  .irq_ready(irq_ready),
  .active_pointer(active_pointer)
);
`default_nettype wire

// file: sprc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// host master model, mode 0, clock idles low between frames
module sprc_host (
  input wire logic clock,
  output var logic sck,
  output var logic cs_n,
  output var logic mosi,
  input wire logic miso
);
  localparam int HALF = 6;
  logic [15:0] rx [0:7];

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(posedge clock);
  endtask

  // ===========================================================
  // one frame: command byte then nw words, msb first
  // byte then 16-bit words
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      input int nw);
    logic [15:0] sh;
    int i;
    sh = 16'h0000;
    cs_n <= 1'b0;
    for (i = 0; i < 8 + 16 * nw; i++) begin
      mosi <= (i < 8) ? cmd[7 - i] : wd[15 - (i - 8) % 16];
      half_wait();
      if (i >= 8) sh = {sh[14:0], miso};
      sck <= 1'b1;
      half_wait();
      sck <= 1'b0;
      if (i >= 8 && (i - 8) % 16 == 15) rx[(i - 8) / 16] = sh;
    end
    half_wait();
    cs_n <= 1'b1;
    repeat (2 * HALF) @(posedge clock);
  endtask
endmodule // sprc_host
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sprc_defines.vh"
module tb_top;
  logic clock, rstn, sck, cs_n, mosi, miso, miso_oe;
  logic flag_set, rt_wr, irq_valid, irq_ready;
  logic [6:0] flag_index;
  logic [12:0] rt_addr;
  logic [15:0] rt_wdata, irq_info, irq_addr_word, active_pointer;
  logic [15:0] table_base;
  int fails, check_count;

  sprc_top #(.AW(13), .FIFO_DEPTH(8), .FIFO_AW(3)) i_sprc_top (
    .clock(clock), .rstn(rstn), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .table_base(table_base),
    .flag_set(flag_set), .flag_index(flag_index), .rt_wr(rt_wr),
    .rt_addr(rt_addr), .rt_wdata(rt_wdata), .irq_valid(irq_valid),
    .irq_ready(irq_ready), .irq_info(irq_info),
    .irq_addr_word(irq_addr_word), .active_pointer(active_pointer)
  );
  sprc_host i_sprc_host (
    .clock(clock), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ===========================================================
  // compare and closing tasks
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic test_done();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ===========================================================
  // stimulus helpers
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {3'b001, a[12:0]};
  endfunction

  task automatic ram_fill(input logic [15:0] lo, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clock);
      rt_wr <= 1'b1;
      rt_addr <= lo[12:0] + i[12:0];
      rt_wdata <= pat(lo + i[15:0]);
    end
    @(posedge clock);
    rt_wr <= 1'b0;
  endtask

  task automatic set_flag(input logic [6:0] idx);
    @(posedge clock);
    flag_set <= 1'b1;
    flag_index <= idx;
    @(posedge clock);
    flag_set <= 1'b0;
  endtask

  task automatic load_ptr(input logic [15:0] p);
    i_sprc_host.xfer(`SPRC_OP_SEL, 16'h0000, 0);
    i_sprc_host.xfer(`SPRC_OP_LOAD, p, 1);
  endtask

  task automatic irq_push(input logic [15:0] info, input logic [15:0] aw);
    int n;
    @(posedge clock);
    n = 0;
    irq_valid <= 1'b1;
    irq_info <= info;
    irq_addr_word <= aw;
    do begin
      @(posedge clock);
      n++;
    end while (irq_ready !== 1'b1 && n < 100);
    irq_valid <= 1'b0;
    if (n >= 100) fails++;
  endtask

  task automatic rd(input logic [7:0] cmd, input int nw);
    i_sprc_host.xfer(cmd, 16'h0000, nw);
  endtask

  // ===========================================================
  // scenarios
  task automatic t_reset();
    cmp_flag(miso_oe, 1'b0);
    cmp_flag(irq_ready, 1'b1);
    cmp_word(active_pointer, 16'h0000);
    rd(`SPRC_OP_RD_LOG, 1);
    cmp_word(i_sprc_host.rx[0], 16'h0180);
  endtask

  task automatic t_seq_halt();
    int k;
    set_flag(7'h00);
    load_ptr(16'h0400);
    cmp_word(active_pointer, 16'h0400);
    rd(`SPRC_OP_SEQ, 6);
    cmp_word(i_sprc_host.rx[0], 16'hA400);
    for (k = 1; k < 6; k++) begin
      cmp_word(i_sprc_host.rx[k], 16'h2400 + (k < 3 ? k[15:0] : 16'h0003));
    end
    cmp_word(active_pointer, 16'h0403);
    rd(`SPRC_OP_RD_PTR, 2);
    cmp_word(i_sprc_host.rx[1], 16'h0403);
    load_ptr(16'h0400);
    rd(`SPRC_OP_SEQ, 1);
    cmp_word(i_sprc_host.rx[0], 16'h2400);
  endtask

  task automatic t_seq_plain();
    int k;
    load_ptr(16'h0100);
    rd(`SPRC_OP_SEQ, 3);
    for (k = 0; k < 3; k++) begin
      cmp_word(i_sprc_host.rx[k], 16'h2100 + k[15:0]);
    end
    cmp_word(active_pointer, 16'h0103);
  endtask

  task automatic t_table();
    int it;
    int k;
    logic [15:0] base;
    load_ptr(16'h03FF);
    for (it = 0; it < 3; it++) begin
      if (it == 2) load_ptr(16'h05FB);
      base = (it == 2) ? 16'h05FC : 16'h0400 + {it[13:0], 2'b00};
      rd(`SPRC_OP_INC, 0);
      cmp_word(active_pointer, base);
      rd(`SPRC_OP_SEQ, 4);
      for (k = 0; k < 4; k++) begin
        cmp_word(i_sprc_host.rx[k], pat(base + k[15:0]));
      end
    end
    cmp_word(active_pointer, 16'h0600);
  endtask

  task automatic t_poll();
    set_flag(7'h01);
    set_flag(7'h02);
    load_ptr(16'h0400);
    rd(`SPRC_OP_POLL, 3);
    cmp_word(i_sprc_host.rx[0], 16'h2400);
    cmp_word(i_sprc_host.rx[1], 16'hA404);
    cmp_word(i_sprc_host.rx[2], 16'hA408);
    cmp_word(active_pointer, 16'h040C);
    load_ptr(16'h0404);
    rd(`SPRC_OP_POLL, 1);
    cmp_word(i_sprc_host.rx[0], 16'h2404);
  endtask

  // moved table base: halt follows the base input, not a fixed address
  task automatic t_base();
    @(posedge clock);
    table_base <= 16'h0402;
    load_ptr(16'h0400);
    rd(`SPRC_OP_SEQ, 4);
    cmp_word(i_sprc_host.rx[0], 16'h2400);
    cmp_word(i_sprc_host.rx[1], 16'h2401);
    cmp_word(i_sprc_host.rx[3], 16'h2401);
    rd(`SPRC_OP_RD_ACTIVE, 1);
    cmp_word(i_sprc_host.rx[0], 16'h0401);
    @(posedge clock);
    table_base <= `SPRC_TABLE_BASE;
  endtask

  task automatic t_log();
    int i;
    logic [15:0] e [0:6];
    for (i = 0; i < 32; i++) irq_push(16'h1100 + i[15:0], 16'h2200 + i[15:0]);
    repeat (40) @(posedge clock);
    rd(`SPRC_OP_LOGRD, 3);
    cmp_word(i_sprc_host.rx[0], 16'h221F);
    cmp_word(i_sprc_host.rx[1], 16'h111F);
    cmp_word(i_sprc_host.rx[2], 16'h221E);
    cmp_word(active_pointer, 16'h01BC);
    rd(`SPRC_OP_RD_LOG, 1);
    cmp_word(i_sprc_host.rx[0], 16'h4180);
    rd(`SPRC_OP_RD_LOG, 1);
    cmp_word(i_sprc_host.rx[0], 16'h0180);
    for (i = 32; i < 35; i++) irq_push(16'h1100 + i[15:0], 16'h2200 + i[15:0]);
    repeat (40) @(posedge clock);
    e = '{16'h2222, 16'h1122, 16'h2221, 16'h1121, 16'h2220, 16'h1120,
          16'h221F};
    rd(`SPRC_OP_LOGRD, 7);
    for (i = 0; i < 7; i++) cmp_word(i_sprc_host.rx[i], e[i]);
    cmp_word(active_pointer, 16'h01BE);
  endtask

  // ===========================================================
  // main sequence and watchdog
  initial begin
    fails = 0;
    check_count = 0;
    rstn = 1'b0;
    table_base = `SPRC_TABLE_BASE;
    flag_set = 1'b0;
    flag_index = 7'h00;
    rt_wr = 1'b0;
    rt_addr = 13'h0000;
    rt_wdata = 16'h0000;
    irq_valid = 1'b0;
    irq_info = 16'h0000;
    irq_addr_word = 16'h0000;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    ram_fill(16'h0100, 4);
    ram_fill(16'h0400, 16);
    ram_fill(16'h05FC, 4);
    t_seq_halt();
    t_seq_plain();
    t_table();
    t_poll();
    t_base();
    t_log();
    test_done();
  end

  // the whole run needs roughly 15k cycles
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
